// file: igec_pkg.sv
// package for the group-two interrupt enable, edge and master control block
// assumes an APB slave with 32-bit data; offsets are printed word indexes
package igec_pkg;
  // ---------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [11:0] IGEC_IDX_REQ = 12'hFC6;
  localparam logic [11:0] IGEC_IDX_ENH = 12'hFC7;
  localparam logic [11:0] IGEC_IDX_ENL = 12'hFC8;
  localparam logic [11:0] IGEC_IDX_PINREQ = 12'hFC3;
  localparam logic [11:0] IGEC_IDX_ES = 12'hFCD;
  localparam logic [11:0] IGEC_IDX_PS = 12'hFCE;
  localparam logic [11:0] IGEC_IDX_CTL = 12'hFCF;
  localparam logic [11:0] IGEC_IDX_ISTAT = 12'hFD0;
  localparam logic [11:0] IGEC_IDX_ICLR = 12'hFD1;
  localparam logic [11:0] IGEC_IDX_IEN = 12'hFD2;
  localparam logic [11:0] IGEC_IDX_VEC = 12'hFD3;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int IGEC_CTL_MASTER_INTERRUPT_ENABLE_BIT = 7;
  localparam int IGEC_SRC_TIMER3 = 7;
  localparam int IGEC_SRC_UART_RX = 6;
  localparam int IGEC_SRC_UART_TX = 5;
  localparam int IGEC_SRC_DMA = 4;
  localparam logic [7:0] IGEC_RST_BYTE = 8'h00;
  localparam logic [1:0] IGEC_LVL_OFF = 2'h0;
  localparam logic [1:0] IGEC_LVL_LOW = 2'h1;
  localparam logic [1:0] IGEC_LVL_NOM = 2'h2;
  localparam logic [1:0] IGEC_LVL_HIGH = 2'h3;
  localparam int IGEC_IST_FWD = 0;
  localparam int IGEC_IST_ACK = 1;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [11:0] idx;
    logic write;
    logic [7:0] wdata;
  } igec_req_t;
  typedef struct packed {
    logic ei;
    logic interrupt_return_instr;
    logic di;
    logic ack;
  } igec_cpu_t;
  typedef enum logic [2:0] {
    IGEC_ST_IDLE = 3'b001,
    IGEC_ST_ACCESS = 3'b010,
    IGEC_ST_DONE = 3'b100
  } igec_apb_st_t;
endpackage : igec_pkg

// file: igec_ctl.sv
// group-two interrupt enables, pin edge and port select, master enable
// assumes pins are asynchronous and cpu strobes are one-cycle pulses on pclk
//
// Functional notes
// - high and low enable bits pair into off, low, nominal, high priority.
// - high enable bit 7 timer3, 6 uart rx, 5 uart tx, 4 dma, 3..0 portc.
// - low enable register uses the same bit mapping as the high register.
// - edge select 0 gives falling edge request, 1 gives rising edge request.
// - pulses wider than two clocks are caught; narrower may be missed.
// - port select 0 takes port A pin, 1 takes port D pin.
// - master enable set by ei, interrupt_return_instr, or software writing one to bit 7.
// - master enable cleared by di, interrupt acknowledge, software writing zero to bit 7, and reset.
// - master enable 0 blocks interrupts; other control bits read zero.
// - a presented request sets its bit in the group-two request register.
// - while disabled, requests stay pending for polling, not forwarded.
`timescale 1ns/10ps
module igec_ctl
  import igec_pkg::*;
#(
  parameter int NPIN = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] group2_src,
  input wire logic [NPIN-1:0] port_a_pin,
  input wire logic [NPIN-1:0] port_d_pin,
  input wire igec_pkg::igec_cpu_t cpu_ctl,
  output logic cpu_irq_req,
  output logic [3:0] cpu_irq_vec,
  output logic [1:0] cpu_irq_level,
  output logic irq
);
  import igec_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // pair the two enable bits of one source into a level
  function automatic logic [1:0] igec_level(input logic hi, input logic lo);
    igec_level = {hi, lo};
  endfunction : igec_level

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic [11:0] word_idx;
  logic addr_ok;
  logic bus_wr;
  logic bus_rd;
  igec_req_t req;
  assign word_idx = paddr[13:2];
  assign addr_ok = (paddr[31:14] == 18'h00000) && (paddr[1:0] == 2'h0) &&
                   (word_idx == IGEC_IDX_REQ || word_idx == IGEC_IDX_ENH ||
                    word_idx == IGEC_IDX_ENL || word_idx == IGEC_IDX_PINREQ ||
                    word_idx == IGEC_IDX_ES || word_idx == IGEC_IDX_PS ||
                    word_idx == IGEC_IDX_CTL || word_idx == IGEC_IDX_ISTAT ||
                    word_idx == IGEC_IDX_ICLR || word_idx == IGEC_IDX_IEN ||
                    word_idx == IGEC_IDX_VEC);
  // zero-wait slave: access phase always completes
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign bus_wr = psel & penable & pwrite & addr_ok & pstrb[0];
  assign bus_rd = psel & penable & ~pwrite & addr_ok;
  assign req.idx = word_idx;
  assign req.write = bus_wr;
  assign req.wdata = pwdata[7:0];

  // ---------------------------------------------------------------
  // pin synchronisers and source select
  // ---------------------------------------------------------------
  logic [NPIN-1:0] sa1_ff, sa2_ff, sa3_ff, sd1_ff, sd2_ff, sd3_ff;
  logic [NPIN-1:0] pin_level_ff;
  logic [NPIN-1:0] nxt_pin_level;
  logic [NPIN-1:0] sel_pin;
  logic [NPIN-1:0] pin_edge;
  logic [7:0] enh_ff, enl_ff, es_ff, ps_ff;
  logic [7:0] nxt_enh, nxt_enl, nxt_es, nxt_ps;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sa1_ff <= '0;
      sa2_ff <= '0;
      sa3_ff <= '0;
      sd1_ff <= '0;
      sd2_ff <= '0;
      sd3_ff <= '0;
      pin_level_ff <= '0;
    end else begin
      sa1_ff <= port_a_pin;
      sa2_ff <= sa1_ff;
      sa3_ff <= sa2_ff;
      sd1_ff <= port_d_pin;
      sd2_ff <= sd1_ff;
      sd3_ff <= sd2_ff;
      pin_level_ff <= nxt_pin_level;
    end
  end

  // filtered level per pin from the selected port
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (ps_ff[i]) begin
        sel_pin[i] = (sd2_ff[i] == sd3_ff[i]) ? sd3_ff[i] : pin_level_ff[i];
      end else begin
        sel_pin[i] = (sa2_ff[i] == sa3_ff[i]) ? sa3_ff[i] : pin_level_ff[i];
      end
    end
    nxt_pin_level = sel_pin;
  end

  // a port switch can fake one edge; software should clear after switching
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (es_ff[i]) begin
        pin_edge[i] = sel_pin[i] & ~pin_level_ff[i];
      end else begin
        pin_edge[i] = ~sel_pin[i] & pin_level_ff[i];
      end
    end
  end
  // stage two and three agreement catches any pulse held over two clocks

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_comb begin
    nxt_enh = enh_ff;
    nxt_enl = enl_ff;
    nxt_es = es_ff;
    nxt_ps = ps_ff;
    if (req.write && req.idx == IGEC_IDX_ENH) begin
      nxt_enh = req.wdata;
    end
    if (req.write && req.idx == IGEC_IDX_ENL) begin
      nxt_enl = req.wdata;
    end
    if (req.write && req.idx == IGEC_IDX_ES) begin
      nxt_es = req.wdata;
    end
    if (req.write && req.idx == IGEC_IDX_PS) begin
      nxt_ps = req.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enh_ff <= IGEC_RST_BYTE;
      enl_ff <= IGEC_RST_BYTE;
      es_ff <= IGEC_RST_BYTE;
      ps_ff <= IGEC_RST_BYTE;
    end else begin
      enh_ff <= nxt_enh;
      enl_ff <= nxt_enl;
      es_ff <= nxt_es;
      ps_ff <= nxt_ps;
    end
  end

  // ---------------------------------------------------------------
  // request registers and master enable
  // ---------------------------------------------------------------
  logic [7:0] req2_ff, nxt_req2;
  logic [NPIN-1:0] pinreq_ff, nxt_pinreq;
  logic master_interrupt_enable_ff, nxt_master_interrupt_enable;
  logic [3:0] win_idx;
  logic [1:0] win_lvl;
  logic win_any;
  logic [3:0] vec_ff, nxt_vec;
  logic [1:0] lvl_ff, nxt_lvl;
  logic fwd_ff, nxt_fwd;

  // winner: highest level first, then highest bit index
  always_comb begin
    logic [1:0] lv;
    lv = IGEC_LVL_OFF;
    win_idx = 4'h0;
    win_lvl = IGEC_LVL_OFF;
    win_any = 1'b0;
    for (int i = 0; i < 8; i++) begin
      lv = igec_level(enh_ff[i], enl_ff[i]);
      if (req2_ff[i] && lv != IGEC_LVL_OFF && (!win_any || lv > win_lvl)) begin
        win_any = 1'b1;
        win_lvl = lv;
        win_idx = 4'(i);
      end else if (req2_ff[i] && lv != IGEC_LVL_OFF && lv == win_lvl) begin
        win_idx = 4'(i);
      end
    end
  end

  // set wins over a software clear in the same cycle
  always_comb begin
    nxt_req2 = req2_ff;
    nxt_pinreq = pinreq_ff;
    if (req.write && req.idx == IGEC_IDX_REQ) begin
      nxt_req2 = req.wdata;
    end
    if (req.write && req.idx == IGEC_IDX_PINREQ) begin
      nxt_pinreq = req.wdata[NPIN-1:0];
    end
    if (cpu_ctl.ack && fwd_ff) begin
      nxt_req2[vec_ff[2:0]] = 1'b0;
    end
    nxt_req2[3:0] = nxt_req2[3:0] | pin_edge[3:0];
    nxt_req2 = nxt_req2 | group2_src;
    nxt_pinreq = nxt_pinreq | pin_edge;
  end

  // hardware strobes outrank a software write; clear outranks set
  always_comb begin
    nxt_master_interrupt_enable = master_interrupt_enable_ff;
    if (req.write && req.idx == IGEC_IDX_CTL && req.wdata[IGEC_CTL_MASTER_INTERRUPT_ENABLE_BIT]) begin
      nxt_master_interrupt_enable = 1'b1;
    end else if (req.write && req.idx == IGEC_IDX_CTL) begin
      nxt_master_interrupt_enable = 1'b0;
    end
    if (cpu_ctl.ei || cpu_ctl.interrupt_return_instr) begin
      nxt_master_interrupt_enable = 1'b1;
    end
    if (cpu_ctl.di || cpu_ctl.ack) begin
      nxt_master_interrupt_enable = 1'b0;
    end
  end

  // forward only while enabled; otherwise requests wait for polling
  always_comb begin
    nxt_fwd = master_interrupt_enable_ff & win_any & ~cpu_ctl.ack;
    nxt_vec = win_any ? win_idx : vec_ff;
    nxt_lvl = win_any ? win_lvl : IGEC_LVL_OFF;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req2_ff <= IGEC_RST_BYTE;
      pinreq_ff <= '0;
      master_interrupt_enable_ff <= 1'b0;
      fwd_ff <= 1'b0;
      vec_ff <= 4'h0;
      lvl_ff <= IGEC_LVL_OFF;
    end else begin
      req2_ff <= nxt_req2;
      pinreq_ff <= nxt_pinreq;
      master_interrupt_enable_ff <= nxt_master_interrupt_enable;
      fwd_ff <= nxt_fwd;
      vec_ff <= nxt_vec;
      lvl_ff <= nxt_lvl;
    end
  end

  assign cpu_irq_req = fwd_ff;
  assign cpu_irq_vec = vec_ff;
  assign cpu_irq_level = lvl_ff;

  // ---------------------------------------------------------------
  // block interrupt status, clear and enable
  // ---------------------------------------------------------------
  logic [1:0] ist_ff, nxt_ist, ien_ff, nxt_ien;
  always_comb begin
    nxt_ist = ist_ff;
    nxt_ien = ien_ff;
    if (req.write && req.idx == IGEC_IDX_ICLR) begin
      nxt_ist = ist_ff & ~req.wdata[1:0];
    end
    if (req.write && req.idx == IGEC_IDX_IEN) begin
      nxt_ien = req.wdata[1:0];
    end
    // events set after the clear so a same-cycle event survives
    if (nxt_fwd && !fwd_ff) begin
      nxt_ist[IGEC_IST_FWD] = 1'b1;
    end
    if (cpu_ctl.ack) begin
      nxt_ist[IGEC_IST_ACK] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_ff <= 2'h0;
      ien_ff <= 2'h0;
    end else begin
      ist_ff <= nxt_ist;
      ien_ff <= nxt_ien;
    end
  end
  assign irq = |(ist_ff & ien_ff);

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    case (word_idx)
      IGEC_IDX_REQ: rd_byte = req2_ff;
      IGEC_IDX_ENH: rd_byte = enh_ff;
      IGEC_IDX_ENL: rd_byte = enl_ff;
      IGEC_IDX_PINREQ: rd_byte = 8'(pinreq_ff);
      IGEC_IDX_ES: rd_byte = es_ff;
      IGEC_IDX_PS: rd_byte = ps_ff;
      IGEC_IDX_CTL: rd_byte = {master_interrupt_enable_ff, 7'h00};
      IGEC_IDX_ISTAT: rd_byte = {6'h00, ist_ff};
      IGEC_IDX_IEN: rd_byte = {6'h00, ien_ff};
      IGEC_IDX_VEC: rd_byte = {2'h0, lvl_ff, vec_ff};
      default: rd_byte = 8'h00;
    endcase
  end
  // read data is combinational over registered state; zero when not reading
  assign prdata = bus_rd ? {24'h000000, rd_byte} : 32'h00000000;
endmodule : igec_ctl

// file: igec_ctl_sva.sv
// checker for igec_ctl: apb read path and master enable effects on the core side
// assumes a bind to every igec_ctl instance; one pclk domain
`timescale 1ns/10ps
module igec_ctl_sva
  import igec_pkg::*;
#(
  parameter int NPIN = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire igec_pkg::igec_cpu_t cpu_ctl,
  input wire logic cpu_irq_req,
  input wire logic [1:0] cpu_irq_level
);
  // -------------------------------------------------------------
  // properties
  // -------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // disable strobe not undone by a set strobe right after
  sequence s_di_quiet;
    cpu_ctl.di ##1 !(cpu_ctl.ei || cpu_ctl.interrupt_return_instr);
  endsequence
  sequence s_ctl_read;
    psel && penable && !pwrite && paddr == {18'h0, IGEC_IDX_CTL, 2'b00};
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_rdata_idle: assert property (!(psel && penable) |-> prdata == 32'h0) else $error("prdata outside access");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr) else $error("pslverr outside access");
  a_upper_zero: assert property (psel && penable |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_ctl_reserved: assert property (s_ctl_read |-> prdata[6:0] == 7'h00) else $error("reserved bits set");
  a_ack_drop: assert property (cpu_ctl.ack |=> !cpu_irq_req) else $error("request after ack");
  a_di_block: assert property (s_di_quiet |=> !cpu_irq_req) else $error("request while disabled");
  a_level_set: assert property (cpu_irq_req |-> cpu_irq_level != IGEC_LVL_OFF) else $error("level off");
endmodule : igec_ctl_sva
bind igec_ctl igec_ctl_sva #(.NPIN(NPIN)) u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cpu_ctl(cpu_ctl), .cpu_irq_req(cpu_irq_req), .cpu_irq_level(cpu_irq_level));

// file: igec_core_model.sv
// core partner: registers bench commands onto cpu_ctl one cycle later and acks requests
// assumes the pclk of igec_ctl; ack_wait sets how slowly the core answers
`timescale 1ns/10ps
module igec_core_model
  import igec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire igec_pkg::igec_cpu_t cmd,
  input wire logic auto_ack,
  input wire logic [3:0] ack_wait,
  input wire logic cpu_irq_req,
  input wire logic [3:0] cpu_irq_vec,
  input wire logic [1:0] cpu_irq_level,
  output igec_pkg::igec_cpu_t cpu_ctl,
  output logic [3:0] taken_vec,
  output logic [1:0] taken_lvl,
  output logic [7:0] taken_cnt
);
  logic [3:0] wait_ff;
  // ack one cycle only, so a request is never taken twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ctl <= '0;
      wait_ff <= 4'h0;
      taken_vec <= 4'h0;
      taken_lvl <= 2'h0;
      taken_cnt <= 8'h00;
    end else begin
      cpu_ctl <= cmd;
      wait_ff <= 4'h0;
      if (auto_ack && cpu_irq_req && !cpu_ctl.ack) begin
        wait_ff <= wait_ff + 4'h1;
        if (wait_ff == ack_wait) begin
          cpu_ctl.ack <= 1'b1;
          taken_vec <= cpu_irq_vec;
          taken_lvl <= cpu_irq_level;
          taken_cnt <= taken_cnt + 8'h01;
        end
      end
    end
  end
endmodule : igec_core_model

// file: igec_ctl_bench.sv
// self-checking bench for igec_ctl: registers, requests, priority, pins, status
// assumes igec_core_model as core partner and the bound igec_ctl_sva checker
`timescale 1ns/10ps
module igec_ctl_bench;
  import igec_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, cpu_irq_req, irq, auto_ack, err;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] pstrb, cpu_irq_vec, taken_vec, ack_wait;
  logic [7:0] group2_src, port_a_pin, port_d_pin, taken_cnt, rd;
  logic [1:0] cpu_irq_level, taken_lvl;
  igec_cpu_t cpu_ctl, cmd;
  logic [11:0] idxs[5] = '{IGEC_IDX_REQ, IGEC_IDX_ENH, IGEC_IDX_ENL, IGEC_IDX_ES, IGEC_IDX_PS};
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  igec_ctl #(.NPIN(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .group2_src(group2_src), .port_a_pin(port_a_pin), .port_d_pin(port_d_pin),
    .cpu_ctl(cpu_ctl), .cpu_irq_req(cpu_irq_req), .cpu_irq_vec(cpu_irq_vec),
    .cpu_irq_level(cpu_irq_level), .irq(irq));
  igec_core_model core (.pclk(pclk), .presetn(presetn), .cmd(cmd), .auto_ack(auto_ack),
    .ack_wait(ack_wait), .cpu_irq_req(cpu_irq_req), .cpu_irq_vec(cpu_irq_vec),
    .cpu_irq_level(cpu_irq_level), .cpu_ctl(cpu_ctl), .taken_vec(taken_vec), .taken_lvl(taken_lvl),
    .taken_cnt(taken_cnt));
  // -------------------------------------------------------------
  // clock, timeout and tasks
  // -------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer plus an idle cycle, so back-to-back calls never reassign psel
  task automatic apb(input logic [11:0] idx, input logic wr, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {18'h0, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask : wr
  task automatic rdchk(input logic [11:0] idx, input logic [7:0] exp);
    apb(idx, 1'b0, 8'h00);
    chk(rd, exp);
  endtask : rdchk
  // how: 0 enable strobe, 1 return strobe, 2 software write of the enable bit
  task automatic take(input logic [7:0] enh, enl, src, input int how, input logic [3:0] v,
                      input logic [1:0] l);
    int n;
    n = taken_cnt;
    wr(IGEC_IDX_ENH, enh);
    wr(IGEC_IDX_ENL, enl);
    group2_src <= src;
    @(posedge pclk);
    group2_src <= 8'h00;
    if (how == 2) wr(IGEC_IDX_CTL, 8'h80);
    else begin
      cmd.ei <= (how == 0);
      cmd.interrupt_return_instr <= (how == 1);
      @(posedge pclk);
      cmd <= '0;
    end
    for (int k = 0; k < 40 && taken_cnt == n; k++) @(posedge pclk);
    chk(taken_vec, v);
    chk(taken_lvl, l);
    rdchk(IGEC_IDX_CTL, 8'h00);
  endtask : take
  // -------------------------------------------------------------
  // tests
  // -------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, cmd} = '0;
    pstrb = 4'hF;
    group2_src = 8'h00;
    port_a_pin = 8'hFF;
    port_d_pin = 8'h00;
    auto_ack = 1'b1;
    ack_wait = 4'h0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) rdchk(idxs[i], 8'h00);
    rdchk(IGEC_IDX_CTL, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(idxs[i], 8'hA5);
      rdchk(idxs[i], 8'hA5);
      wr(idxs[i], 8'h00);
    end
    wr(IGEC_IDX_CTL, 8'hFF);
    rdchk(IGEC_IDX_CTL, 8'h80);
    wr(IGEC_IDX_CTL, 8'h00);
    rdchk(IGEC_IDX_CTL, 8'h00);
    wr(12'h000, 8'h55);
    chk(err, 1'b1);
    pstrb <= 4'hE;
    wr(IGEC_IDX_ENH, 8'hFF);
    pstrb <= 4'hF;
    rdchk(IGEC_IDX_ENH, 8'h00);
    // the port select toggles above fake falling edges; drop those requests
    wr(IGEC_IDX_REQ, 8'h00);
    wr(IGEC_IDX_PINREQ, 8'h00);
    $display("test registers done");
    wr(IGEC_IDX_ENH, 8'hFF);
    group2_src <= 8'h90;
    @(posedge pclk);
    group2_src <= 8'h00;
    repeat (3) @(posedge pclk);
    rdchk(IGEC_IDX_REQ, 8'h90);
    chk(cpu_irq_req, 1'b0);
    take(8'h10, 8'h80, 8'h00, 0, 4'h4, 2'h2);
    take(8'h10, 8'h80, 8'h00, 1, 4'h7, 2'h1);
    take(8'h81, 8'h80, 8'h81, 2, 4'h7, 2'h3);
    take(8'h81, 8'h80, 8'h00, 2, 4'h0, 2'h2);
    take(8'h09, 8'h00, 8'h09, 0, 4'h3, 2'h2);
    take(8'h09, 8'h00, 8'h00, 1, 4'h0, 2'h2);
    ack_wait <= 4'h3;
    for (int i = 0; i < 8; i++)
      take(i[0] ? 8'h01 << i : 8'h00, i[0] ? 8'h00 : 8'h01 << i, 8'h01 << i, i % 3, i[3:0],
           i[0] ? 2'h2 : 2'h1);
    $display("test priority done");
    // core silent: request must stay up with its vector and level
    auto_ack <= 1'b0;
    wr(IGEC_IDX_ENH, 8'h01);
    wr(IGEC_IDX_ENL, 8'h00);
    group2_src <= 8'h01;
    cmd.ei <= 1'b1;
    @(posedge pclk);
    group2_src <= 8'h00;
    cmd <= '0;
    repeat (4) @(posedge pclk);
    chk(cpu_irq_req, 1'b1);
    chk(cpu_irq_vec, 4'h0);
    chk(cpu_irq_level, 2'h2);
    rdchk(IGEC_IDX_VEC, 8'h20);
    cmd.di <= 1'b1;
    @(posedge pclk);
    cmd <= '0;
    repeat (3) @(posedge pclk);
    chk(cpu_irq_req, 1'b0);
    rdchk(IGEC_IDX_REQ, 8'h01);
    wr(IGEC_IDX_REQ, 8'h00);
    auto_ack <= 1'b1;
    wr(IGEC_IDX_IEN, 8'h00);
    chk(irq, 1'b0);
    wr(IGEC_IDX_IEN, 8'h02);
    chk(irq, 1'b1);
    rdchk(IGEC_IDX_ISTAT, 8'h03);
    wr(IGEC_IDX_ICLR, 8'h03);
    rdchk(IGEC_IDX_ISTAT, 8'h00);
    chk(irq, 1'b0);
    $display("test status done");
    wr(IGEC_IDX_ENH, 8'h00);
    wr(IGEC_IDX_ES, 8'h02);
    wr(IGEC_IDX_PS, 8'h02);
    wr(IGEC_IDX_PINREQ, 8'h00);
    wr(IGEC_IDX_REQ, 8'h00);
    // pins held 8 cycles, wider than the capture minimum
    port_a_pin <= 8'hFC;
    port_d_pin <= 8'h02;
    repeat (8) @(posedge pclk);
    port_a_pin <= 8'hFD;
    repeat (8) @(posedge pclk);
    rdchk(IGEC_IDX_PINREQ, 8'h03);
    rdchk(IGEC_IDX_REQ, 8'h03);
    wr(IGEC_IDX_PINREQ, 8'h00);
    port_d_pin <= 8'h00;
    repeat (8) @(posedge pclk);
    rdchk(IGEC_IDX_PINREQ, 8'h00);
    $display("test pins done");
    end_sim();
  end
endmodule : igec_ctl_bench
